/* File: verilog/fvc_params.svh */
`ifndef FVC_PARAMS_SVH
`define FVC_PARAMS_SVH
// Notes on behaviour
// - bit 7 low enables parity and read-data checking in octal DDR reads.
// - bit 6 high: all lines same in training; low inverts line 3.
// - bits 5:4 pick program check chunk: 00 to 11 give 128, 64, 32 or 16 bytes.
// - bit 3 low enables parity and program-data checking in octal DDR.
// - bit 2 picks error pin event: two-bit detect (1) or correction (0).
// - bit 1 low lets the error pin signal; high keeps it inactive.
// - bit 0 low turns correction on; default is off.
// - byte 0Ah holds training pattern, sent MSB first, default 55h.
// - wrap byte: FFh continuous, FEh 64, FDh 32, FCh 16 bytes.
// - execute-in-place byte: FEh enables, FFh disables; host confirms later.
// - address byte: FFh three address bytes, FEh four address bytes.
// - drive byte: FFh 50, FEh 35, FDh 25, FCh 18 ohm.
// - dummy byte: 01h-1Eh give cycle count; 1Fh and 00h mean default.
// - I/O byte: FFh, DFh extended; E7h, C7h octal DDR; strobe varies.
// - octal-boot parts accept only octal DDR with strobe.
// - correction event counter saturates at 15.
// - reads of reserved addresses return FFh.
// - reserved writes are ignored, set flag bit 1, clear write enable.

// register addresses
`define FVC_ADDR_IO      8'h00
`define FVC_ADDR_DUMMY   8'h01
`define FVC_ADDR_DRIVE   8'h03
`define FVC_ADDR_AWIDTH  8'h05
`define FVC_ADDR_XIP     8'h06
`define FVC_ADDR_WRAP    8'h07
`define FVC_ADDR_TRAIN   8'h0A
`define FVC_ADDR_INTEG   8'h0B

// reset values
`define FVC_RST_IO       8'hFF
`define FVC_RST_DUMMY    8'h1F
`define FVC_RST_DRIVE    8'hFF
`define FVC_RST_AWIDTH   8'hFF
`define FVC_RST_XIP      8'hFF
`define FVC_RST_WRAP     8'hFF
`define FVC_RST_TRAIN    8'h55
`define FVC_RST_INTEG    8'hFF
`define FVC_RSVD_READ    8'hFF

// integrity control field positions
`define FVC_BIT_RDCHK    7
`define FVC_BIT_SSO      6
`define FVC_BIT_SIZE_HI  5
`define FVC_BIT_SIZE_LO  4
`define FVC_BIT_PGCHK    3
`define FVC_BIT_ERRSEL   2
`define FVC_BIT_ERRDIS   1
`define FVC_BIT_CORRDIS  0

// setting codes
`define FVC_CODE_FF      8'hFF
`define FVC_CODE_FE      8'hFE
`define FVC_CODE_FD      8'hFD
`define FVC_CODE_FC      8'hFC
`define FVC_CODE_EXT_NS  8'hDF
`define FVC_CODE_ODDR    8'hE7
`define FVC_CODE_ODDR_NS 8'hC7
`define FVC_DUMMY_MAX    8'h1E
`define FVC_DUMMY_DEF    8'h1F
`define FVC_DUMMY_ZERO   8'h00
`define FVC_COUNT_MAX    4'hF
`define FVC_LINE_INV     3
`endif

/* File: verilog/fvc_pkg.sv */
package fvc_pkg;
   typedef enum logic [1:0] {
      fvc_io_ext_strobe,
      fvc_io_ext_plain,
      fvc_io_oddr_strobe,
      fvc_io_oddr_plain
   } fvc_io_e;
   typedef enum logic [1:0] {
      fvc_wrap_none,
      fvc_wrap_64,
      fvc_wrap_32,
      fvc_wrap_16
   } fvc_wrap_e;
   typedef enum logic [1:0] {
      fvc_drive_50,
      fvc_drive_35,
      fvc_drive_25,
      fvc_drive_18
   } fvc_drive_e;
   typedef enum logic [1:0] {
      fvc_chunk_128,
      fvc_chunk_64,
      fvc_chunk_32,
      fvc_chunk_16
   } fvc_chunk_e;
endpackage

/* File: verilog/fvc_bank.sv */
`timescale 1ns/1ps
`include "fvc_params.svh"
module fvc_bank
   import fvc_pkg::*;
(
   // clock and reset
   input  wire logic       clock,
   input  wire logic       arst_n,
   // factory strap, caught after reset
   input  wire logic       boot_octal_ddr,
   // register command port from the command decoder
   input  wire logic       cmd_write,
   input  wire logic       cmd_read,
   input  wire logic [7:0] cmd_addr,
   input  wire logic [7:0] cmd_wdata,
   output logic [7:0]      cmd_rdata,
   output logic            cmd_rvalid,
   output logic            rsvd_write_flag_set,
   output logic            write_enable_clear,
   // decoded settings
   output fvc_io_e         io_mode,
   output logic [4:0]      dummy_count,
   output logic            dummy_use_default,
   output fvc_drive_e      drive_select,
   output logic            address_four_bytes,
   output logic            xip_enabled,
   output fvc_wrap_e       wrap_select,
   output logic            read_check_enable,
   output logic            program_check_enable,
   output fvc_chunk_e      program_check_chunk_size,
   output logic            correction_enable,
   // correction events from the array path
   input  wire logic       corr_event,
   input  wire logic       detect_event,
   input  wire logic [27:0] event_chunk_addr,
   input  wire logic       error_status_clear,
   output logic [3:0]      correction_event_count,
   output logic [27:0]     failing_chunk_address,
   output logic            error_pin_n,
   // training pattern drive
   input  wire logic       link_clk,
   input  wire logic       train_active,
   output logic [7:0]      dq_out,
   output logic            dq_oe
);
   // ==========================================================
   // storage
   logic [7:0] io_byte;
   logic [7:0] dummy_byte;
   logic [7:0] drive_byte;
   logic [7:0] awidth_byte;
   logic [7:0] xip_byte;
   logic [7:0] wrap_byte;
   logic [7:0] training_pattern;
   logic [7:0] integ_byte;
   logic       octal_part;
   logic       strap_taken;
   logic [1:0] strap_sync;
   logic [1:0] strap_wait;

   // ==========================================================
   // write decode
   wire hit_io     = cmd_addr == `FVC_ADDR_IO;
   wire hit_dummy  = cmd_addr == `FVC_ADDR_DUMMY;
   wire hit_drive  = cmd_addr == `FVC_ADDR_DRIVE;
   wire hit_awidth = cmd_addr == `FVC_ADDR_AWIDTH;
   wire hit_xip    = cmd_addr == `FVC_ADDR_XIP;
   wire hit_wrap   = cmd_addr == `FVC_ADDR_WRAP;
   wire hit_train  = cmd_addr == `FVC_ADDR_TRAIN;
   wire hit_integ  = cmd_addr == `FVC_ADDR_INTEG;

   wire code_four  = cmd_wdata == `FVC_CODE_FF || cmd_wdata == `FVC_CODE_FE
                  || cmd_wdata == `FVC_CODE_FD || cmd_wdata == `FVC_CODE_FC;
   wire code_two   = cmd_wdata == `FVC_CODE_FF
                  || cmd_wdata == `FVC_CODE_FE;
   wire code_dummy = cmd_wdata <= `FVC_DUMMY_DEF;
   wire code_io_ext  = cmd_wdata == `FVC_CODE_FF
                    || cmd_wdata == `FVC_CODE_EXT_NS
                    || cmd_wdata == `FVC_CODE_ODDR_NS;
   wire code_io    = octal_part ? cmd_wdata == `FVC_CODE_ODDR
                   : (code_io_ext || cmd_wdata == `FVC_CODE_ODDR);

   wire ok_io     = hit_io && code_io;
   wire ok_dummy  = hit_dummy && code_dummy;
   wire ok_drive  = hit_drive && code_four;
   wire ok_awidth = hit_awidth && code_two;
   wire ok_xip    = hit_xip && code_two;
   wire ok_wrap   = hit_wrap && code_four;
   wire ok_any    = ok_io || ok_dummy || ok_drive || ok_awidth || ok_xip
                 || ok_wrap || hit_train || hit_integ;
   wire rsvd_wr   = cmd_write && !ok_any;

   // ==========================================================
   // registers
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         io_byte          <= `FVC_RST_IO;
         dummy_byte       <= `FVC_RST_DUMMY;
         drive_byte       <= `FVC_RST_DRIVE;
         awidth_byte      <= `FVC_RST_AWIDTH;
         xip_byte         <= `FVC_RST_XIP;
         wrap_byte        <= `FVC_RST_WRAP;
         training_pattern <= `FVC_RST_TRAIN;
         integ_byte       <= `FVC_RST_INTEG;
      end else if (cmd_write) begin
         if (ok_io) io_byte <= cmd_wdata;
         if (ok_dummy) dummy_byte <= cmd_wdata;
         if (ok_drive) drive_byte <= cmd_wdata;
         if (ok_awidth) awidth_byte <= cmd_wdata;
         if (ok_xip) xip_byte <= cmd_wdata;
         if (ok_wrap) wrap_byte <= cmd_wdata;
         if (hit_train) training_pattern <= cmd_wdata;
         if (hit_integ) integ_byte <= cmd_wdata;
      end
   end

   // strap synchronised, then caught once after reset release
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         strap_sync  <= 2'b00;
         strap_wait  <= 2'b00;
         octal_part  <= 1'b0;
         strap_taken <= 1'b0;
      end else begin
         strap_sync <= {strap_sync[0], boot_octal_ddr};
         strap_wait <= {strap_wait[0], 1'b1};
         if (strap_wait[1] && !strap_taken) begin
            octal_part  <= strap_sync[1];
            strap_taken <= 1'b1;
         end
      end
   end

   // ==========================================================
   // read path and reserved write pulses
   logic [7:0] next_rdata;
   always_comb begin
      if (hit_io) next_rdata = io_byte;
      else if (hit_dummy) next_rdata = dummy_byte;
      else if (hit_drive) next_rdata = drive_byte;
      else if (hit_awidth) next_rdata = awidth_byte;
      else if (hit_xip) next_rdata = xip_byte;
      else if (hit_wrap) next_rdata = wrap_byte;
      else if (hit_train) next_rdata = training_pattern;
      else if (hit_integ) next_rdata = integ_byte;
      else next_rdata = `FVC_RSVD_READ;
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cmd_rdata           <= 8'h00;
         cmd_rvalid          <= 1'b0;
         rsvd_write_flag_set <= 1'b0;
         write_enable_clear  <= 1'b0;
      end else begin
         cmd_rvalid          <= cmd_read;
         if (cmd_read) cmd_rdata <= next_rdata;
         rsvd_write_flag_set <= rsvd_wr;
         write_enable_clear  <= rsvd_wr;
      end
   end

   // ==========================================================
   // decoded settings
   always_comb begin
      if (octal_part) io_mode = fvc_io_oddr_strobe;
      else if (io_byte == `FVC_CODE_EXT_NS) io_mode = fvc_io_ext_plain;
      else if (io_byte == `FVC_CODE_ODDR) io_mode = fvc_io_oddr_strobe;
      else if (io_byte == `FVC_CODE_ODDR_NS) io_mode = fvc_io_oddr_plain;
      else io_mode = fvc_io_ext_strobe;
   end

   assign dummy_use_default = dummy_byte == `FVC_DUMMY_DEF
                           || dummy_byte == `FVC_DUMMY_ZERO;
   assign dummy_count = dummy_byte[4:0];

   assign drive_select = fvc_drive_e'(~drive_byte[1:0]);
   assign wrap_select  = fvc_wrap_e'(~wrap_byte[1:0]);
   assign address_four_bytes = awidth_byte == `FVC_CODE_FE;
   assign xip_enabled = xip_byte == `FVC_CODE_FE;

   assign read_check_enable = !integ_byte[`FVC_BIT_RDCHK];
   assign program_check_enable = !integ_byte[`FVC_BIT_PGCHK];
   assign program_check_chunk_size = fvc_chunk_e'(
      integ_byte[`FVC_BIT_SIZE_HI:`FVC_BIT_SIZE_LO]);
   assign correction_enable = !integ_byte[`FVC_BIT_CORRDIS];

   // ==========================================================
   // correction events and error pin
   wire sel_detect = integ_byte[`FVC_BIT_ERRSEL];
   wire sel_event  = correction_enable
                  && (sel_detect ? detect_event : corr_event);
   logic err_flag;
   logic addr_held;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         correction_event_count <= 4'h0;
         failing_chunk_address  <= 28'h0000000;
         addr_held              <= 1'b0;
         err_flag               <= 1'b0;
      end else begin
         if (correction_enable && corr_event
             && correction_event_count != `FVC_COUNT_MAX)
            correction_event_count <= correction_event_count + 4'h1;
         if (sel_event && !addr_held) begin
            failing_chunk_address <= event_chunk_addr;
            addr_held             <= 1'b1;
         end else if (error_status_clear) begin
            addr_held <= 1'b0;
         end
         if (sel_event) err_flag <= 1'b1;
         else if (error_status_clear) err_flag <= 1'b0;
      end
   end

   assign error_pin_n = !(err_flag && !integ_byte[`FVC_BIT_ERRDIS]);

   // ==========================================================
   // training pattern drive on link clock edges
   logic [1:0] lclk_sync;
   logic [1:0] act_sync;
   logic       lclk_prev;
   logic [2:0] bit_idx;

   wire lclk_rise = lclk_sync[1] && !lclk_prev;
   wire pat_bit   = training_pattern[3'h7 - bit_idx];
   wire sso_on    = !integ_byte[`FVC_BIT_SSO];
   wire [7:0] inv_mask = sso_on ? (8'h01 << `FVC_LINE_INV) : 8'h00;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         lclk_sync <= 2'b00;
         act_sync  <= 2'b00;
         lclk_prev <= 1'b0;
         bit_idx   <= 3'h0;
         dq_out    <= 8'h00;
         dq_oe     <= 1'b0;
      end else begin
         lclk_sync <= {lclk_sync[0], link_clk};
         act_sync  <= {act_sync[0], train_active};
         lclk_prev <= lclk_sync[1];
         dq_oe     <= act_sync[1];
         if (!act_sync[1]) begin
            bit_idx <= 3'h0;
         end else if (lclk_rise) begin
            dq_out  <= {8{pat_bit}} ^ inv_mask;
            bit_idx <= bit_idx + 3'h1;
         end
      end
   end
endmodule

/* File: verification/fvc_bank_asserts.sv */
`timescale 1ns/1ps
// ==========================================
// register bank checker
module fvc_bank_asserts (
   // clock and reset
   input wire logic       clock,
   input wire logic       arst_n,
   // register port
   input wire logic       cmd_write,
   input wire logic       cmd_read,
   input wire logic [7:0] cmd_addr,
   input wire logic [7:0] cmd_wdata,
   input wire logic [7:0] cmd_rdata,
   input wire logic       cmd_rvalid,
   input wire logic       rsvd_write_flag_set,
   input wire logic       write_enable_clear,
   // decoded settings
   input wire logic       address_four_bytes,
   input wire logic       xip_enabled,
   input wire logic       read_check_enable,
   input wire logic       program_check_enable,
   input wire logic       correction_enable,
   // events
   input wire logic       corr_event,
   input wire logic       detect_event,
   input wire logic [3:0] correction_event_count,
   input wire logic       error_pin_n
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);
   wire mapped = cmd_addr inside {8'h00, 8'h01, 8'h03, 8'h05,
                                  8'h06, 8'h07, 8'h0A, 8'h0B};
   sequence s_wr(logic [7:0] a);
      cmd_write && cmd_addr == a;
   endsequence
   sequence s_bad;
      cmd_write && (!mapped || cmd_addr == 8'h07 && cmd_wdata < 8'hFC);
   endsequence
   property p_rd_rsvd;
      cmd_read && !mapped |=> cmd_rvalid && cmd_rdata == 8'hFF;
   endproperty
   a_rd_rsvd: assert property (p_rd_rsvd) else $error("bad read");
   property p_wr_rsvd;
      s_bad |=> rsvd_write_flag_set && write_enable_clear;
   endproperty
   a_wr_rsvd: assert property (p_wr_rsvd) else $error("no flag");
   property p_chk_en;
      s_wr(8'h0B) |=> read_check_enable == !$past(cmd_wdata[7])
         && program_check_enable == !$past(cmd_wdata[3]);
   endproperty
   a_chk_en: assert property (p_chk_en) else $error("check");
   property p_corr_en;
      s_wr(8'h0B) |=> correction_enable == !$past(cmd_wdata[0]);
   endproperty
   a_corr_en: assert property (p_corr_en) else $error("corr");
   property p_awidth;
      s_wr(8'h05) ##0 cmd_wdata[7:1] == 7'h7F
         |=> address_four_bytes == !$past(cmd_wdata[0]);
   endproperty
   a_awidth: assert property (p_awidth) else $error("awidth");
   property p_xip;
      s_wr(8'h06) ##0 cmd_wdata[7:1] == 7'h7F
         |=> xip_enabled == !$past(cmd_wdata[0]);
   endproperty
   a_xip: assert property (p_xip) else $error("xip");
   property p_sat;
      correction_event_count == 4'hF |=> correction_event_count == 4'hF;
   endproperty
   a_sat: assert property (p_sat) else $error("count");
   property p_pin;
      $fell(error_pin_n) |-> $past(detect_event || corr_event)
         || $past(cmd_write && cmd_addr == 8'h0B && !cmd_wdata[1]);
   endproperty
   a_pin: assert property (p_pin) else $error("pin");
endmodule

bind fvc_bank fvc_bank_asserts u_fvc_bank_asserts (.*);

/* File: verification/fvc_host_model.sv */
`timescale 1ns/1ps
// ==========================================
// host side of the training link
module fvc_host_model (
   // frame request
   input  wire logic go,
   // link pins
   output logic      link_clk,
   output logic      train_active
);
   // link clock stands low outside the frame
   initial begin
      link_clk = 1'b0;
      train_active = 1'b0;
      @(posedge go);
      #7;
      train_active = 1'b1;
      #200;
      repeat (8) begin
         link_clk = 1'b1;
         #80;
         link_clk = 1'b0;
         #80;
      end
      train_active = 1'b0;
   end
endmodule

/* File: verification/fvc_bank_tb.sv */
`timescale 1ns/1ps
// ==========================================
// register bank bench
module fvc_bank_tb;
   import fvc_pkg::*;
   logic clock, arst_n, boot_octal_ddr, cmd_write, cmd_read, go;
   logic [7:0] cmd_addr, cmd_wdata, cmd_rdata, dq_out;
   logic cmd_rvalid, rsvd_write_flag_set, write_enable_clear;
   fvc_io_e io_mode;
   fvc_drive_e drive_select;
   fvc_wrap_e wrap_select;
   fvc_chunk_e program_check_chunk_size;
   logic [4:0] dummy_count;
   logic dummy_use_default, address_four_bytes, xip_enabled;
   logic read_check_enable, program_check_enable, correction_enable;
   logic corr_event, detect_event, error_status_clear, error_pin_n;
   logic link_clk, train_active, dq_oe;
   logic [27:0] event_chunk_addr, failing_chunk_address;
   logic [3:0] correction_event_count;
   logic [7:0] dflt [0:12];
   logic [7:0] io_c [0:3];
   int bad_count, n_tests;
   fvc_bank u_fvc_bank (.*);
   fvc_host_model u_fvc_host_model (.*);
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   // ==========================================
   // access tasks
   task chk(input string nm, input logic [27:0] e, input logic [27:0] g);
      n_tests++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock); #1;
      cmd_write = 1'b1; cmd_addr = a; cmd_wdata = d;
      @(posedge clock); #1;
      cmd_write = 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clock); #1;
      cmd_read = 1'b1; cmd_addr = a;
      @(posedge clock); #1;
      cmd_read = 1'b0;
      chk("cmd_rvalid", 1, cmd_rvalid);
      chk("cmd_rdata", e, cmd_rdata);
   endtask
   task ev(input logic c, input logic d);
      @(posedge clock); #1;
      corr_event = c; detect_event = d;
      @(posedge clock); #1;
      corr_event = 1'b0; detect_event = 1'b0;
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      #200000;
      bad_count++;
      wrap_up();
   end
   // ==========================================
   // tests
   initial begin
      {arst_n, boot_octal_ddr, cmd_write, cmd_read, go} = 5'h00;
      {corr_event, detect_event, error_status_clear} = 3'h0;
      cmd_addr = 8'h00; cmd_wdata = 8'h00; event_chunk_addr = 28'hABCDE12;
      dflt = '{8'hFF, 8'h1F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
               8'hFF, 8'hFF, 8'hFF, 8'h55, 8'hFF, 8'hFF};
      io_c = '{8'hFF, 8'hDF, 8'hE7, 8'hC7};
      repeat (8) @(posedge clock);
      #1 arst_n = 1'b1;
      repeat (2) @(posedge clock);
      for (int i = 0; i < 13; i++) rd(i[7:0], dflt[i]);
      for (int i = 0; i < 4; i++) begin
         wr(8'h00, io_c[i]);
         chk("io_mode", i, io_mode);
         wr(8'h07, 8'hFF - i[7:0]);
         chk("wrap_select", i, wrap_select);
         wr(8'h03, 8'hFF - i[7:0]);
         chk("drive_select", i, drive_select);
      end
      wr(8'h07, 8'hFB);
      chk("flag_set", 1, rsvd_write_flag_set);
      chk("we_clear", 1, write_enable_clear);
      rd(8'h07, 8'hFC);
      wr(8'h02, 8'h00);
      rd(8'h02, 8'hFF);
      wr(8'h05, 8'hFE);
      chk("addr4", 1, address_four_bytes);
      wr(8'h06, 8'hFE);
      chk("xip", 1, xip_enabled);
      wr(8'h06, 8'hFF);
      chk("xip", 0, xip_enabled);
      wr(8'h01, 8'h1E);
      chk("dummy", 5'h1E, {dummy_use_default, dummy_count});
      wr(8'h01, 8'h00);
      chk("dummy_def", 1, dummy_use_default);
      wr(8'h0B, 8'h44);
      chk("checks", 3,
          {read_check_enable, program_check_enable});
      chk("chunk", 0, program_check_chunk_size);
      chk("corr_en", 1, correction_enable);
      repeat (17) ev(1'b1, 1'b0);
      chk("count", 15, correction_event_count);
      chk("pin_corr", 1, error_pin_n);
      ev(1'b0, 1'b1);
      chk("pin_det", 0, error_pin_n);
      chk("fca", 28'hABCDE12, failing_chunk_address);
      @(posedge clock); #1 error_status_clear = 1'b1;
      @(posedge clock); #1 error_status_clear = 1'b0;
      chk("pin_clr", 1, error_pin_n);
      wr(8'h0B, 8'h46);
      ev(1'b0, 1'b1);
      chk("pin_off", 1, error_pin_n);
      wr(8'h0A, 8'hA5);
      wr(8'h0B, 8'h00);
      go = 1'b1;
      for (int k = 0; k < 8; k++) begin
         @(posedge link_clk);
         repeat (5) @(posedge clock);
         #1;
         chk("dq_oe", 1, dq_oe);
         chk("dq_out", ((8'hA5 >> (7 - k)) & 8'h01) ? 8'hF7 : 8'h08,
             dq_out);
      end
      // ==========================================
      // second reset as an octal-boot part
      boot_octal_ddr = 1'b1;
      arst_n = 1'b0;
      repeat (2) @(posedge clock);
      #1 arst_n = 1'b1;
      repeat (2) @(posedge clock);
      #1;
      chk("count_rst", 0, correction_event_count);
      wr(8'h00, 8'hFF);
      chk("oct_flag", 1, rsvd_write_flag_set);
      chk("oct_mode", 2, io_mode);
      wr(8'h00, 8'hE7);
      chk("oct_ok", 0, rsvd_write_flag_set);
      rd(8'h00, 8'hE7);
      wr(8'h0B, 8'hF8);
      chk("chunk16", 3, program_check_chunk_size);
      event_chunk_addr = 28'h0123456;
      ev(1'b1, 1'b0);
      chk("pin_csel", 0, error_pin_n);
      chk("fca_csel", 28'h0123456, failing_chunk_address);
      wrap_up();
   end
endmodule
